/* hw/bse_pkg.sv */
/*
  Shared types and constants of the bit, shift and transfer execution unit.
  Assumes a decoder upstream that fills bse_instr_t for one instruction at a time.
*/
package bse_pkg;

  // ****************************************************************
  // Widths, flag positions and register indices
  // ****************************************************************
  localparam int          DW       = 8;
  localparam int          AW       = 16;
  localparam int          NREG     = 32;
  localparam int          MSB      = 7;
  localparam logic [2:0]  FLAG_C   = 3'h0;
  localparam logic [2:0]  FLAG_Z   = 3'h1;
  localparam logic [2:0]  FLAG_N   = 3'h2;
  localparam logic [2:0]  FLAG_V   = 3'h3;
  localparam logic [2:0]  FLAG_T   = 3'h6;
  localparam logic [4:0]  REG_R0   = 5'h00;
  localparam logic [4:0]  REG_R1   = 5'h01;
  localparam logic [4:0]  PTR_X_LO = 5'h1a;
  localparam logic [4:0]  PTR_Y_LO = 5'h1c;
  localparam logic [4:0]  PTR_Z_LO = 5'h1e;
  localparam logic [4:0]  HI_BYTE  = 5'h01;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [15:0] ONE16    = 16'h0001;
  localparam logic [7:0]  BIT0     = 8'h01;

  // ****************************************************************
  // Operations, pointer pairs and addressing modes
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_NOP, OP_SET_IO_BIT, OP_CLEAR_IO_BIT, OP_SHIFT_LEFT_LOGICAL,
    OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
    OP_SHIFT_RIGHT_ARITH, OP_SWAP, OP_FLAG_SET, OP_FLAG_CLEAR,
    OP_BIT_TO_TRANSFER_FLAG, OP_TRANSFER_FLAG_TO_BIT, OP_LOAD_INDIRECT,
    OP_STORE_INDIRECT, OP_DIRECT_LOAD, OP_DIRECT_STORE, OP_PROGRAM_MEMORY_LOAD,
    OP_PROGRAM_MEMORY_LOAD_R0, OP_PROGRAM_MEMORY_STORE, OP_PUSH, OP_POP,
    OP_SLEEP, OP_WATCHDOG_KICK
  } bse_op_t;

  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} bse_ptr_t;
  typedef enum logic [1:0] {AM_PLAIN, AM_POST_INC, AM_PRE_DEC, AM_DISP} bse_amode_t;
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_EX2 = 2'h1, ST_EX3 = 2'h3,
                            ST_STORE_WAIT = 2'h2} bse_state_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    bse_op_t    op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bitsel;
    bse_ptr_t   ptr;
    bse_amode_t amode;
    logic [5:0] disp;
    logic [5:0] io_addr;
    logic [15:0] addr;
  } bse_instr_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        re;
    logic        we;
    logic [7:0]  wdata;
  } bse_dmem_t;

  typedef struct packed {
    logic [5:0] addr;
    logic       re;
  } bse_io_t;

  typedef struct packed {
    logic        req;
    logic [15:0] addr;
    logic [15:0] data;
  } bse_pst_t;

endpackage

/* hw/bse_exec.sv */
/*
  Execution unit for bit, shift, flag, data transfer and core control instructions,
  holding the 32 working registers, the status register and the stack pointer.
  Assumes combinational read data from data memory, I/O space and program memory
  in the same cycle the address is presented, and one instruction offered at a time.
*/
// Operation
// RL1: Set or clear one I/O bit, flags untouched, two cycles.
// RL2: Left shift inserts zero, rotate left inserts carry; one cycle, Z C N V.
// RL3: Right shift inserts zero, rotate right inserts carry; one cycle, Z C N V.
// RL4: Arithmetic right shift keeps bit seven; one cycle, Z C N V.
// RL5: Single-cycle set or clear of each status flag, only that flag.
// RL6: Bit store copies register bit to T; bit load copies T back.
// RL7: Indirect load through X, Y or Z, optional post-increment, two cycles.
// RL8: Pre-decrement load lowers pointer first, then reads new address.
// RL9: Displacement load only through Y or Z, pointer kept, two cycles.
// RL10: Indirect store, plain, post-increment or pre-decrement, two cycles.
// RL11: Displacement store through Y or Z, pointer kept, two cycles.
// RL12: Direct load and store use the instruction address word, two cycles.
// RL13: Program memory load via Z, three cycles, R0 by default, optional increment.
// RL14: Push and pop use the stack, two cycles, flags untouched.
// RL15: Sleep and watchdog kick take one cycle, flags untouched.
// RL16: Shift carry is the bit shifted out; overflow is N xor C.
// RL17: Program memory store sends R1:R0 at Z, waits for completion.
`timescale 1ns/100ps
module bse_exec
  import bse_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                instr_valid,
  input  wire bse_pkg::bse_instr_t instr,
  output      logic                instr_ready,
  output      bse_pkg::bse_dmem_t  dmem,
  input  wire logic [7:0]          dmem_rdata,
  output      bse_pkg::bse_io_t    io,
  output      logic                io_we,
  output      logic [7:0]          io_wdata,
  input  wire logic [7:0]          io_rdata,
  output      logic [15:0]         pmem_addr,
  input  wire logic [15:0]         pmem_rdata,
  output      bse_pkg::bse_pst_t   pstore,
  input  wire logic                pstore_done,
  output      logic                sleep_req,
  output      logic                watchdog_kick,
  output      logic [7:0]          status_register,
  output      logic [15:0]         stack_ptr,
  input  wire logic [4:0]          dbg_index,
  output      logic [7:0]          reg_value
);
  import bse_pkg::*;

  // ****************************************************************
  // State and decode
  // ****************************************************************
  bse_state_t  state;
  bse_state_t  next_state;
  logic [7:0]  regs [NREG];
  bse_op_t     pend_op;
  logic [4:0]  pend_dst;
  logic        pend_hi;
  logic [7:0]  pend_mask;
  logic [7:0]  next_status_register;

  wire         accept    = instr_valid && (state == ST_IDLE);
  bse_op_t     op;
  assign op = instr.op;
  wire  [7:0]  rd_val    = regs[instr.rd];
  wire  [7:0]  rr_val    = regs[instr.rr];
  wire  [7:0]  bit_mask  = BIT0 << instr.bitsel;
  wire         carry     = status_register[FLAG_C];
  wire         t_flag    = status_register[FLAG_T];

  assign instr_ready = (state == ST_IDLE);
  assign reg_value   = regs[dbg_index];

  wire is_ld   = (op == OP_LOAD_INDIRECT);
  wire is_st   = (op == OP_STORE_INDIRECT);
  wire is_pload = (op == OP_PROGRAM_MEMORY_LOAD) || (op == OP_PROGRAM_MEMORY_LOAD_R0);
  wire is_io   = (op == OP_SET_IO_BIT) || (op == OP_CLEAR_IO_BIT);
  wire is_dmem = is_ld || is_st || (op == OP_DIRECT_LOAD) || (op == OP_DIRECT_STORE)
                 || (op == OP_PUSH) || (op == OP_POP);
  wire is_rd_mem = is_ld || (op == OP_DIRECT_LOAD) || (op == OP_POP);

  // ****************************************************************
  // Pointer pairs and effective address
  // ****************************************************************
  wire [4:0]  ptr_lo  = (is_pload || (op == OP_PROGRAM_MEMORY_STORE)) ? PTR_Z_LO : // RL13 RL17
                        (instr.ptr == PTR_X) ? PTR_X_LO :
                        (instr.ptr == PTR_Y) ? PTR_Y_LO : PTR_Z_LO;
  wire [4:0]  ptr_hi  = ptr_lo | HI_BYTE;
  wire [15:0] ptr_val = {regs[ptr_hi], regs[ptr_lo]};
  wire [15:0] ptr_inc = ptr_val + ONE16;
  wire [15:0] ptr_dec = ptr_val - ONE16;
  wire        disp_ok = (instr.ptr != PTR_X);
  wire [15:0] disp16  = disp_ok ? AW'(instr.disp) : '0; // RL9 RL11
  wire [15:0] eff_addr = (instr.amode == AM_PRE_DEC) ? ptr_dec :                // RL8
                         (instr.amode == AM_DISP)    ? ptr_val + disp16 :       // RL9
                         ptr_val;                                               // RL7 RL10
  wire        ptr_upd = accept && (((is_ld || is_st) && ((instr.amode == AM_POST_INC)
                        || (instr.amode == AM_PRE_DEC)))
                        || ((op == OP_PROGRAM_MEMORY_LOAD) && (instr.amode == AM_POST_INC)));
  wire [15:0] ptr_new = (instr.amode == AM_PRE_DEC) ? ptr_dec : ptr_inc;        // RL7 RL13

  // ****************************************************************
  // Shift, rotate, swap and bit load
  // ****************************************************************
  logic [7:0] alu_res;
  logic       sh_c;
  always_comb
  begin
    alu_res = rd_val;
    sh_c    = carry;
    unique case (op)
      OP_SHIFT_LEFT_LOGICAL:
      begin
        alu_res = {rd_val[MSB-1:0], 1'b0};   // RL2
        sh_c    = rd_val[MSB];               // RL16
      end
      OP_ROTATE_LEFT_CARRY:
      begin
        alu_res = {rd_val[MSB-1:0], carry};  // RL2
        sh_c    = rd_val[MSB];               // RL16
      end
      OP_SHIFT_RIGHT_LOGICAL:
      begin
        alu_res = {1'b0, rd_val[MSB:1]};     // RL3
        sh_c    = rd_val[0];                 // RL16
      end
      OP_ROTATE_RIGHT_CARRY:
      begin
        alu_res = {carry, rd_val[MSB:1]};    // RL3
        sh_c    = rd_val[0];                 // RL16
      end
      OP_SHIFT_RIGHT_ARITH:
      begin
        alu_res = {rd_val[MSB], rd_val[MSB:1]}; // RL4
        sh_c    = rd_val[0];                 // RL16
      end
      OP_SWAP:
        alu_res = {rd_val[3:0], rd_val[MSB:4]};
      OP_TRANSFER_FLAG_TO_BIT:
        alu_res = t_flag ? (rd_val | bit_mask) : (rd_val & ~bit_mask); // RL6
      default:
        alu_res = rd_val;
    endcase
  end

  wire is_shift = (op == OP_SHIFT_LEFT_LOGICAL) || (op == OP_SHIFT_RIGHT_LOGICAL)
                  || (op == OP_ROTATE_LEFT_CARRY) || (op == OP_ROTATE_RIGHT_CARRY)
                  || (op == OP_SHIFT_RIGHT_ARITH);
  wire alu_wr   = accept && (is_shift || (op == OP_SWAP) || (op == OP_TRANSFER_FLAG_TO_BIT));

  // ****************************************************************
  // Status register
  // ****************************************************************
  always_comb
  begin
    next_status_register = status_register;
    if (accept && is_shift)
    begin
      next_status_register[FLAG_C] = sh_c;                       // RL2 RL3 RL4
      next_status_register[FLAG_Z] = (alu_res == '0);
      next_status_register[FLAG_N] = alu_res[MSB];
      next_status_register[FLAG_V] = alu_res[MSB] ^ sh_c;        // RL16
    end
    else if (accept && (op == OP_FLAG_SET))
      next_status_register = status_register | bit_mask;         // RL5
    else if (accept && (op == OP_FLAG_CLEAR))
      next_status_register = status_register & ~bit_mask;        // RL5
    else if (accept && (op == OP_BIT_TO_TRANSFER_FLAG))
      next_status_register[FLAG_T] = |(rr_val & bit_mask);       // RL6
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      status_register <= '0;
    else
      status_register <= next_status_register;
  end

  // ****************************************************************
  // Memory return and register file
  // ****************************************************************
  wire        load_wr   = ((state == ST_EX2) && (pend_op inside {OP_LOAD_INDIRECT,
                          OP_DIRECT_LOAD, OP_POP})) || (state == ST_EX3);
  wire [7:0]  load_data = (state == ST_EX3) ? (pend_hi ? pmem_rdata[15:8] : pmem_rdata[7:0])
                          : dmem_rdata;

  for (genvar i = 0; i < NREG; i++)
  begin : g_reg
    always_ff @(posedge clk)
    begin
      if (!nrst)
        regs[i] <= '0;
      else if (load_wr && (pend_dst == 5'(i)))
        regs[i] <= load_data;                        // RL7 RL12 RL13 RL14
      else if (alu_wr && (instr.rd == 5'(i)))
        regs[i] <= alu_res;                          // RL2 RL6
      else if (ptr_upd && (ptr_lo == 5'(i)))
        regs[i] <= ptr_new[7:0];                     // RL7 RL8 RL10
      else if (ptr_upd && (ptr_hi == 5'(i)))
        regs[i] <= ptr_new[15:8];
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (accept && (is_io || is_dmem || is_pload))
          next_state = ST_EX2;                       // RL1 RL12 RL14
        else if (accept && (op == OP_PROGRAM_MEMORY_STORE))
          next_state = ST_STORE_WAIT;                // RL17
      ST_EX2:
        next_state = (pend_op == OP_PROGRAM_MEMORY_LOAD) ? ST_EX3 : ST_IDLE; // RL13
      ST_EX3:
        next_state = ST_IDLE;
      ST_STORE_WAIT:
        if (pstore_done)
          next_state = ST_IDLE;
    endcase
  end

  wire [4:0] dst = (op == OP_PROGRAM_MEMORY_LOAD_R0) ? REG_R0 : instr.rd; // RL13

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state     <= ST_IDLE;
      pend_op   <= OP_NOP;
      pend_dst  <= '0;
      pend_hi   <= 1'b0;
      pend_mask <= '0;
    end
    else
    begin
      state <= next_state;
      if (accept)
      begin
        pend_op   <= is_pload ? OP_PROGRAM_MEMORY_LOAD : op;
        pend_dst  <= dst;
        pend_hi   <= ptr_val[0];
        pend_mask <= bit_mask;
      end
    end
  end

  // ****************************************************************
  // Data memory, stack, I/O and program memory requests
  // ****************************************************************
  wire [15:0] sp_inc = stack_ptr + ONE16;
  wire [15:0] next_dmem_addr = (is_ld || is_st) ? eff_addr :
                               (op == OP_PUSH) ? stack_ptr :      // RL14
                               (op == OP_POP)  ? sp_inc : instr.addr; // RL12

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      dmem      <= '0;
      io        <= '0;
      stack_ptr <= SP_RESET;
      pmem_addr <= '0;
    end
    else
    begin
      dmem.re    <= accept && is_dmem && is_rd_mem;
      dmem.we    <= accept && is_dmem && !is_rd_mem;  // RL10 RL11 RL12
      io.re      <= accept && is_io;                  // RL1
      if (accept && is_dmem)
      begin
        dmem.addr  <= next_dmem_addr;
        dmem.wdata <= rr_val;
      end
      if (accept && is_io)
        io.addr <= instr.io_addr;
      if (accept && (op == OP_PUSH))
        stack_ptr <= stack_ptr - ONE16;               // RL14
      else if (accept && (op == OP_POP))
        stack_ptr <= sp_inc;
      if (accept && is_pload)
        pmem_addr <= ptr_val;                         // RL13
    end
  end

  assign io_we    = (state == ST_EX2) && ((pend_op == OP_SET_IO_BIT)
                    || (pend_op == OP_CLEAR_IO_BIT));                 // RL1
  assign io_wdata = (pend_op == OP_SET_IO_BIT) ? (io_rdata | pend_mask)
                    : (io_rdata & ~pend_mask);                         // RL1

  // ****************************************************************
  // Self-programming, sleep and watchdog
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pstore        <= '0;
      sleep_req     <= 1'b0;
      watchdog_kick <= 1'b0;
    end
    else
    begin
      pstore.req    <= accept && (op == OP_PROGRAM_MEMORY_STORE); // RL17
      sleep_req     <= accept && (op == OP_SLEEP);                // RL15
      watchdog_kick <= accept && (op == OP_WATCHDOG_KICK);        // RL15
      if (accept && (op == OP_PROGRAM_MEMORY_STORE))
      begin
        pstore.addr <= ptr_val;
        pstore.data <= {regs[REG_R1], regs[REG_R0]};
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_io_bit_write: assert property (accept && is_io |=> io_we ##1 instr_ready) // RL1
    else $error("io bit op not two cycles");
  chk_io_flags_kept: assert property (accept && is_io |=> $stable(status_register)) // RL1
    else $error("io bit op changed flags");
  chk_rotl_carry_in: assert property (accept && (op == OP_ROTATE_LEFT_CARRY) |=> // RL2
    (regs[$past(instr.rd)][0] == $past(carry)) && (carry == $past(rd_val[MSB])))
    else $error("rotate left wrong");
  chk_shr_msb_zero: assert property (accept && (op == OP_SHIFT_RIGHT_LOGICAL) |=> // RL3
    !regs[$past(instr.rd)][MSB] && (carry == $past(rd_val[0])) && instr_ready)
    else $error("right shift wrong");
  chk_arith_sign_kept: assert property (accept && (op == OP_SHIFT_RIGHT_ARITH) |=> // RL4
    regs[$past(instr.rd)][MSB] == $past(rd_val[MSB]))
    else $error("arith shift lost sign");
  chk_flag_set_only: assert property (accept && (op == OP_FLAG_SET) |=> // RL5
    status_register == ($past(status_register) | $past(bit_mask)))
    else $error("flag set touched other flags");
  chk_tflag_copy: assert property (accept && (op == OP_BIT_TO_TRANSFER_FLAG) |=> // RL6
    t_flag == $past(|(rr_val & bit_mask)))
    else $error("bit store wrong");
  chk_ld_predec_addr: assert property (accept && is_ld && (instr.amode == AM_PRE_DEC) |=> // RL8
    dmem.re && (dmem.addr == $past(ptr_dec)) ##1 instr_ready)
    else $error("pre-decrement load wrong");
  chk_disp_ptr_kept: assert property (accept && (is_ld || is_st) // RL9
    && (instr.amode == AM_DISP) |=>
    ({regs[$past(ptr_hi)], regs[$past(ptr_lo)]} == $past(ptr_val)))
    else $error("displacement moved pointer");
  chk_pload_three_cyc: assert property (accept && is_pload |=> // RL13
    !instr_ready ##1 !instr_ready ##1 instr_ready)
    else $error("program load not three cycles");
  chk_push_stack: assert property (accept && (op == OP_PUSH) |=> // RL14
    dmem.we && (stack_ptr == $past(stack_ptr) - ONE16) && $stable(status_register))
    else $error("push wrong");
  chk_sleep_one_cyc: assert property (accept && (op == OP_SLEEP) |=> // RL15
    sleep_req && instr_ready && $stable(status_register))
    else $error("sleep not one cycle");
  chk_pstore_wait: assert property ((state == ST_STORE_WAIT) && !pstore_done |=> // RL17
    !instr_ready)
    else $error("store to program memory not waited");

endmodule

/* tb/bse_mem_model.sv */
/*
  Far side of the execution unit: data memory, I/O space, program memory
  and a slow self-programming unit. Assumes the unit's single clock.
*/
`timescale 1ns/100ps
module bse_mem_model
  import bse_pkg::*;
#(
  parameter int STORE_WAIT = 3
)
(
  input  wire logic               clk,
  input  wire bse_pkg::bse_dmem_t dmem,
  output      logic [7:0]         dmem_rdata,
  input  wire bse_pkg::bse_io_t   io,
  input  wire logic               io_we,
  input  wire logic [7:0]         io_wdata,
  output      logic [7:0]         io_rdata,
  input  wire logic [15:0]        pmem_addr,
  output      logic [15:0]        pmem_rdata,
  input  wire bse_pkg::bse_pst_t  pstore,
  output      logic               pstore_done
);
  logic [7:0] mem [256];
  logic [7:0] ioreg [64];
  logic [7:0] junk;
  int         cnt;

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h3c;
    for (int i = 0; i < 64; i++)
      ioreg[i] = 8'(i) ^ 8'ha5;
    junk = 8'h96;
    cnt = 0;
  end

  // Unselected read lines show a pattern that changes every cycle
  assign dmem_rdata = dmem.re ? mem[dmem.addr[7:0]] : junk;
  assign io_rdata   = io.re ? ioreg[io.addr] : ~junk;
  assign pmem_rdata = {pmem_addr[8:1] ^ 8'hc3, pmem_addr[8:1]};
  assign pstore_done = (cnt == 1);

  always @(posedge clk)
  begin
    junk <= junk + 8'h5b;
    if (dmem.we)
      mem[dmem.addr[7:0]] <= dmem.wdata;
    if (io_we)
      ioreg[io.addr] <= io_wdata;
    if (pstore.req)
      cnt <= STORE_WAIT;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule

/* tb/testbench.sv */
/*
  Self-checking bench of the execution unit.
  Assumes the far-side model fills data memory with address xor 0x3c.
*/
`timescale 1ns/100ps
module testbench;
  import bse_pkg::*;
  logic       clk, nrst, instr_valid, instr_ready, io_we, pstore_done;
  logic       sleep_req, watchdog_kick;
  bse_instr_t instr;
  bse_dmem_t  dmem, s_dmem;
  bse_io_t    io;
  bse_pst_t   pstore, s_pst;
  logic [7:0] dmem_rdata, io_wdata, io_rdata, status_register, reg_value, sr;
  logic [15:0] pmem_addr, pmem_rdata, stack_ptr, s_io;
  logic [4:0] dbg_index;
  logic [1:0] s_pulse;
  int         n_fail, checks;

  bse_exec dut (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .dmem(dmem), .dmem_rdata(dmem_rdata), .io(io),
    .io_we(io_we), .io_wdata(io_wdata), .io_rdata(io_rdata), .pmem_addr(pmem_addr),
    .pmem_rdata(pmem_rdata), .pstore(pstore), .pstore_done(pstore_done), .sleep_req(sleep_req),
    .watchdog_kick(watchdog_kick), .status_register(status_register),
    .stack_ptr(stack_ptr), .dbg_index(dbg_index), .reg_value(reg_value));
  bse_mem_model mem_u (.clk(clk), .dmem(dmem), .dmem_rdata(dmem_rdata), .io(io),
    .io_we(io_we), .io_wdata(io_wdata), .io_rdata(io_rdata), .pmem_addr(pmem_addr),
    .pmem_rdata(pmem_rdata), .pstore(pstore), .pstore_done(pstore_done));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic bse_instr_t mk(bse_op_t op, int r, int b, int p, int m, int a);
    mk = '{op, 5'(r), 5'(r), 3'(b), bse_ptr_t'(p), bse_amode_t'(m), 6'(a), 6'(a), 16'(a)};
  endfunction

  task automatic run(input bse_instr_t i, input int cyc);
    int n;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr       <= i;
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    s_dmem  = dmem;
    s_io    = {io, io_we, io_wdata};
    s_pulse = {sleep_req, watchdog_kick};
    s_pst   = pstore;
    n = 1;
    while (instr_ready !== 1'b1 && n < 40)
    begin
      n++;
      @(negedge clk);
    end
    if (cyc > 0)
      chk(n, cyc);
  endtask

  task automatic creg(input int r, input logic [7:0] v);
    @(posedge clk);
    dbg_index <= 5'(r);
    @(negedge clk);
    chk(reg_value, v);
  endtask

  task automatic setr(input int r, input logic [7:0] v);
    run(mk(OP_DIRECT_LOAD, r, 0, 0, 0, {8'h00, v ^ 8'h3c}), 2);
    chk({s_dmem.addr, s_dmem.re}, {8'h00, v ^ 8'h3c, 1'b1});
    creg(r, v);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_flags;
    for (int s = 0; s < 8; s++)
    begin
      run(mk(OP_FLAG_SET, 0, s, 0, 0, 0), 1);
      sr[s] = 1'b1;
      chk(status_register, sr);
      if (s % 2 == 0)
      begin
        run(mk(OP_FLAG_CLEAR, 0, s, 0, 0, 0), 1);
        sr[s] = 1'b0;
        chk(status_register, sr);
      end
    end
  endtask

  task automatic t_shift;
    bse_op_t    ops[5];
    logic [7:0] vs[3];
    logic [7:0] r;
    logic       c;
    logic       co;
    ops = '{OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY,
            OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH};
    vs = '{8'h81, 8'h00, 8'h40};
    for (int j = 0; j < 5; j++)
      for (int k = 0; k < 6; k++)
      begin
        c = k % 2;
        setr(16, vs[k / 2]);
        run(mk(c ? OP_FLAG_SET : OP_FLAG_CLEAR, 0, 0, 0, 0, 0), 1);
        run(mk(ops[j], 16, 0, 0, 0, 0), 1);
        case (j)
          0: {co, r} = {vs[k / 2], 1'b0};
          1: {r, co} = {1'b0, vs[k / 2]};
          2: {co, r} = {vs[k / 2], c};
          3: {r, co} = {c, vs[k / 2]};
          default: {r, co} = {vs[k / 2][7], vs[k / 2]};
        endcase
        sr[3:0] = {r[7] ^ co, r[7], r == 8'h00, co};
        chk(status_register, sr);
        creg(16, r);
      end
  endtask

  task automatic t_bits;
    setr(5, 8'h20);
    setr(7, 8'h00);
    run(mk(OP_BIT_TO_TRANSFER_FLAG, 5, 5, 0, 0, 0), 1);
    sr[6] = 1'b1;
    run(mk(OP_TRANSFER_FLAG_TO_BIT, 7, 2, 0, 0, 0), 1);
    creg(7, 8'h04);
    run(mk(OP_BIT_TO_TRANSFER_FLAG, 5, 0, 0, 0, 0), 1);
    sr[6] = 1'b0;
    run(mk(OP_TRANSFER_FLAG_TO_BIT, 5, 5, 0, 0, 0), 1);
    creg(5, 8'h00);
    chk(status_register, sr);
  endtask

  task automatic t_io;
    run(mk(OP_SET_IO_BIT, 0, 3, 0, 0, 16'h0012), 2);
    chk(s_io, {6'h12, 1'b1, 1'b1, 8'hbf});
    run(mk(OP_CLEAR_IO_BIT, 0, 4, 0, 0, 16'h0012), 2);
    chk(s_io, {6'h12, 1'b1, 1'b1, 8'haf});
    chk(status_register, sr);
  endtask

  task automatic t_mem;
    logic [15:0] a;
    logic [7:0]  np;
    setr(9, 8'h77);
    for (int st = 0; st < 2; st++)
      for (int p = 0; p < 3; p++)
        for (int m = 0; m < 4; m++)
          if (p != 0 || m != 3)
          begin
            setr(26 + 2 * p, 8'h30);
            setr(27 + 2 * p, 8'h00);
            run(mk(st ? OP_STORE_INDIRECT : OP_LOAD_INDIRECT, st ? 9 : 4, 0, p, m, 5), 2);
            a = (m == 2) ? 16'h002f : (m == 3) ? 16'h0035 : 16'h0030;
            np = (m == 1) ? 8'h31 : (m == 2) ? 8'h2f : 8'h30;
            chk({s_dmem.addr, s_dmem.re, s_dmem.we}, {a, st == 0, st == 1});
            if (st)
              chk(s_dmem.wdata, 8'h77);
            else
              creg(4, a[7:0] ^ 8'h3c);
            creg(26 + 2 * p, np);
          end
    run(mk(OP_DIRECT_STORE, 9, 0, 0, 0, 16'h00c4), 2);
    chk({s_dmem.addr, s_dmem.we, s_dmem.wdata}, {16'h00c4, 1'b1, 8'h77});
  endtask

  task automatic t_pmem;
    setr(30, 8'h41);
    setr(31, 8'h00);
    run(mk(OP_PROGRAM_MEMORY_LOAD_R0, 3, 0, 2, 0, 0), 3);
    chk(pmem_addr, 16'h0041);
    creg(0, 8'he3);
    run(mk(OP_PROGRAM_MEMORY_LOAD, 3, 0, 2, 1, 0), 3);
    creg(3, 8'he3);
    creg(30, 8'h42);
    run(mk(OP_PROGRAM_MEMORY_LOAD, 3, 0, 2, 0, 0), 3);
    creg(3, 8'h21);
  endtask

  task automatic t_misc;
    setr(8, 8'h5e);
    run(mk(OP_PUSH, 8, 0, 0, 0, 0), 2);
    chk({s_dmem.addr, s_dmem.we, s_dmem.wdata, stack_ptr}, {16'h00ff, 1'b1, 8'h5e, 16'h00fe});
    run(mk(OP_POP, 10, 0, 0, 0, 0), 2);
    chk({s_dmem.addr, s_dmem.re, stack_ptr}, {16'h00ff, 1'b1, 16'h00ff});
    creg(10, 8'h5e);
    run(mk(OP_SLEEP, 0, 0, 0, 0, 0), 1);
    chk(s_pulse, 2'b10);
    run(mk(OP_WATCHDOG_KICK, 0, 0, 0, 0, 0), 1);
    chk({s_pulse, status_register}, {2'b01, sr});
    setr(1, 8'h9d);
    run(mk(OP_PROGRAM_MEMORY_STORE, 0, 0, 2, 0, 0), 5);
    chk({s_pst.req, s_pst.addr}, {1'b1, 16'h0042});
    chk(s_pst.data, 16'h9de3);
  endtask

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude;
  end

  initial
  begin
    nrst = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    dbg_index = 5'h00;
    n_fail = 0;
    checks = 0;
    sr = 8'h00;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk({status_register, stack_ptr, instr_ready}, {8'h00, 16'h00ff, 1'b1});
    t_flags;
    t_shift;
    t_bits;
    t_io;
    t_mem;
    t_pmem;
    t_misc;
    conclude;
  end
endmodule
